/* File: common/flash_prot_pkg.sv */
/*
 * constants for the flash protection and security controller: register map, field positions,
 * reset values, command codes and configuration-area addresses.
 * assumes a byte-addressed flash read port and a 32-bit avalon-mm register bus.
 */
package flash_prot_pkg;
    // register byte offsets
    localparam logic [5:0]  OFS_STATUS   = 6'h00;
    localparam logic [5:0]  OFS_CONFIG   = 6'h04;
    localparam logic [5:0]  OFS_PROT     = 6'h08;
    localparam logic [5:0]  OFS_SEC      = 6'h0c;
    localparam logic [5:0]  OFS_CMD      = 6'h10;
    localparam logic [5:0]  OFS_KEY0     = 6'h14;
    localparam logic [5:0]  OFS_KEY_STEP = 6'h04;
    localparam int          NUM_KEYS     = 4;
    // status and config fields
    localparam int          ST_CMD_COMPLETE_FLAG      = 7;
    localparam int          ST_KEYREJ    = 5;
    localparam int          ST_PVIOL     = 4;
    localparam int          CFG_COMPLETE_IRQ_ENABLE     = 7;
    // protection fields
    localparam int          PROT_OPEN    = 7;
    localparam int          PROT_HDIS    = 5;
    localparam int          PROT_HS_LO   = 3;
    localparam logic [7:0]  PROT_MASK    = 8'hb8;
    localparam logic [7:0]  PROT_RST     = 8'hb8;
    // security fields
    localparam int          SEC_BACKDOOR_KEY_ENABLE_LO = 6;
    localparam int          SEC_STATE_LO = 0;
    localparam logic [7:0]  SEC_MASK     = 8'hc3;
    localparam logic [7:0]  SEC_RST      = 8'h00;
    localparam logic [1:0]  SEC_UNSECURED = 2'h2;
    localparam logic [1:0]  BACKDOOR_KEY_ENABLE_ENABLED = 2'h2;
    // command codes
    localparam logic [7:0]  CMD_ERASE_ALL   = 8'h08;
    localparam logic [7:0]  CMD_ERASE_BLOCK = 8'h09;
    localparam logic [7:0]  CMD_KEY_VERIFY  = 8'h0c;
    // configuration area in flash
    localparam logic [15:0] FA_KEY       = 16'hff70;
    localparam logic [15:0] FA_PROT      = 16'hff7c;
    localparam logic [15:0] FA_NVBYTE    = 16'hff7e;
    localparam logic [15:0] FA_SEC       = 16'hff7f;
    localparam logic [15:0] FA_TOP       = 16'hffff;
    localparam logic [15:0] HIGH_MIN_SZ  = 16'h0800;
    localparam logic [3:0]  LOAD_BYTES   = 4'h2;
    localparam logic [3:0]  KEY_BYTES    = 4'h8;
    localparam logic [15:0] KEY_ZERO     = 16'h0000;
    localparam logic [15:0] KEY_ONES     = 16'hffff;

    // fetch sequencer states, gray along idle-issue-wait-capture-done
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_ISSUE = 3'h1,
        S_WAIT  = 3'h3,
        S_CAPT  = 3'h2,
        S_DONE  = 3'h6
    } fetch_state_t;
endpackage : flash_prot_pkg

/* File: common/flash_fetch_if.sv */
/*
 * carrier between the controller and its flash fetch sequencer.
 * assumes both ends run on the same clock.
 */
interface flash_fetch_if;
    logic        start_load;   // pulse: read protection and security bytes
    logic        start_key;    // pulse: read and compare backdoor keys
    logic [15:0] key [4];      // presented keys
    logic        done;         // pulse: sequence finished
    logic        match;        // keys matched, valid with done
    logic [7:0]  prot_byte;
    logic [7:0]  sec_byte;
    logic [15:0] flash_addr;
    logic        flash_rd;
    logic [7:0]  flash_rdata;

    modport ctrl (output start_load, start_key, key, flash_rdata,
                  input done, match, prot_byte, sec_byte, flash_addr, flash_rd);
    modport seq  (input start_load, start_key, key, flash_rdata,
                  output done, match, prot_byte, sec_byte, flash_addr, flash_rd);
endinterface : flash_fetch_if

/* File: src/flash_fetch_seq.sv */
/*
 * byte-wise fetch of the configuration area: loads the protection and security bytes,
 * or reads the stored backdoor keys and compares them with presented ones.
 * assumes flash data is valid one cycle after the read strobe rises.
 */
module flash_fetch_seq
    import flash_prot_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  reset_in,
    input  wire logic  ce_in,
    flash_fetch_if.seq fif
);
    fetch_state_t state_ff;
    logic [3:0]   idx_ff;
    logic         mode_key_ff;
    logic [7:0]   hi_ff;
    logic         match_ff;
    logic [15:0]  addr_ff;
    logic         rd_ff;
    logic [7:0]   prot_ff;
    logic [7:0]   sec_ff;
    logic         done_ff;
    logic [15:0]  exp_word;
    logic [7:0]   exp_byte;

    assign exp_word = fif.key[idx_ff[2:1]];
    assign exp_byte = idx_ff[0] ? exp_word[7:0] : exp_word[15:8];

    ////////////////////////////////////////////////////////////////////////////
    // sequence control and flash strobe
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff    <= S_IDLE;
            idx_ff      <= 4'h0;
            mode_key_ff <= 1'b0;
            addr_ff     <= 16'h0000;
            rd_ff       <= 1'b0;
            done_ff     <= 1'b0;
        end else if (ce_in) begin
            done_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    idx_ff <= 4'h0;
                    if (fif.start_load || fif.start_key) begin
                        mode_key_ff <= fif.start_key;
                        state_ff    <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    rd_ff    <= 1'b1;
                    addr_ff  <= mode_key_ff ? (FA_KEY + {12'h000, idx_ff})
                                            : ((idx_ff == 4'h0) ? FA_PROT : FA_SEC);
                    state_ff <= S_WAIT;
                end
                S_WAIT: begin
                    rd_ff    <= 1'b0;
                    state_ff <= S_CAPT;
                end
                S_CAPT: begin
                    idx_ff   <= idx_ff + 4'h1;
                    state_ff <= (idx_ff == (mode_key_ff ? KEY_BYTES : LOAD_BYTES) - 4'h1)
                                ? S_DONE : S_ISSUE;
                end
                S_DONE: begin
                    done_ff  <= 1'b1;
                    state_ff <= S_IDLE;
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // captured bytes and key comparison
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            hi_ff    <= 8'h00;
            match_ff <= 1'b0;
            prot_ff  <= PROT_RST;
            sec_ff   <= SEC_RST;
        end else if (ce_in) begin
            if (state_ff == S_IDLE) begin
                match_ff <= 1'b1;
            end else if (state_ff == S_CAPT) begin
                if (!mode_key_ff) begin
                    if (idx_ff == 4'h0) begin
                        prot_ff <= fif.flash_rdata;
                    end else begin
                        sec_ff <= fif.flash_rdata;
                    end
                end else begin
                    if (fif.flash_rdata != exp_byte) begin
                        match_ff <= 1'b0;
                    end
                    if (idx_ff[0] && ({hi_ff, fif.flash_rdata} == KEY_ZERO ||
                                      {hi_ff, fif.flash_rdata} == KEY_ONES)) begin
                        match_ff <= 1'b0;
                    end
                    hi_ff <= fif.flash_rdata;
                end
            end
        end
    end

    assign fif.done       = done_ff;
    assign fif.match      = match_ff;
    assign fif.prot_byte  = prot_ff;
    assign fif.sec_byte   = sec_ff;
    assign fif.flash_addr = addr_ff;
    assign fif.flash_rd   = rd_ff;
endmodule : flash_fetch_seq

/* File: src/flash_protect_security_ctrl.sv */
/*
 * flash protection and security controller with command-complete flag and interrupt.
 * assumes an avalon-mm master, a byte flash read port, and an external command engine
 * that runs every command except key verify and answers with cmd_done_in.
 */
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
module flash_protect_security_ctrl
    import flash_prot_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        ce_in,
    input  wire logic [5:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic      [15:0] flash_addr_out,
    output logic             flash_rd_out,
    input  wire logic [7:0]  flash_rdata_in,
    output logic             flash_read_block_out,
    output logic             cmd_launch_out,
    output logic      [7:0]  cmd_code_out,
    input  wire logic        cmd_done_in,
    output logic             irq_out,
    output logic             prot_high_out,
    output logic             prot_low_out,
    output logic      [15:0] high_base_out,
    output logic             secured_out
);
    flash_fetch_if fif ();

    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic        loaded_ff;
    logic        load_req_ff;
    logic        cmd_complete_flag_ff;
    logic        pviol_ff;
    logic        keyrej_ff;
    logic        complete_irq_enable_ff;
    logic [7:0]  prot_ff;
    logic [7:0]  sec_ff;
    logic        lock_ff;
    logic        secured_ff;
    logic [7:0]  cmd_ff;
    logic [15:0] key_ff [NUM_KEYS];
    logic        key_run_ff;
    logic        key_start_ff;
    logic        ext_run_ff;
    logic        launch_ff;
    logic        irq_ff;
    logic        high_ff;
    logic        low_ff;
    logic [15:0] base_ff;

    logic        wr_take;
    logic        launch_req;
    logic        key_refuse;
    logic        erase_refuse;
    logic        launch_key;
    logic        launch_ext;
    logic        nxt_cmd_complete_flag;
    logic        nxt_complete_irq_enable;
    logic [7:0]  wr_prot;
    logic        prot_ok;

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then the request completes
    assign wr_take = avs_write_in && !wait_ff;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wait_ff <= 1'b1;
        end else if (ce_in) begin
            wait_ff <= !((avs_read_in || avs_write_in) && wait_ff);
        end
    end

    // read data mux, loaded while waitrequest is still high
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (ce_in && avs_read_in && wait_ff) begin
            rdata_ff <= 32'h0000_0000;
            case (avs_address_in)
                OFS_STATUS: begin
                    rdata_ff[ST_CMD_COMPLETE_FLAG]   <= cmd_complete_flag_ff;
                    rdata_ff[ST_KEYREJ] <= keyrej_ff;
                    rdata_ff[ST_PVIOL]  <= pviol_ff;
                end
                OFS_CONFIG: rdata_ff[CFG_COMPLETE_IRQ_ENABLE] <= complete_irq_enable_ff;
                OFS_PROT:   rdata_ff[7:0] <= prot_ff;
                OFS_SEC:    rdata_ff[7:0] <= sec_ff;
                OFS_CMD:    rdata_ff[7:0] <= cmd_ff;
                default: begin
                    for (int k = 0; k < NUM_KEYS; k++) begin
                        if (avs_address_in == OFS_KEY0 + 6'(k) * OFS_KEY_STEP) begin
                            rdata_ff[15:0] <= key_ff[k];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command launch decision
    // write one to the flag launches
    assign launch_req   = wr_take && avs_address_in == OFS_STATUS && avs_byteenable_in[0]
                          && avs_writedata_in[ST_CMD_COMPLETE_FLAG] && cmd_complete_flag_ff && loaded_ff;
    assign key_refuse   = cmd_ff == CMD_KEY_VERIFY &&
                          (lock_ff || sec_ff[SEC_BACKDOOR_KEY_ENABLE_LO +: 2] != BACKDOOR_KEY_ENABLE_ENABLED);
    assign erase_refuse = (cmd_ff == CMD_ERASE_ALL || cmd_ff == CMD_ERASE_BLOCK) &&
                          !(prot_ff[PROT_OPEN] && prot_ff[PROT_HDIS]);
    assign launch_key   = launch_req && cmd_ff == CMD_KEY_VERIFY && !key_refuse;
    assign launch_ext   = launch_req && cmd_ff != CMD_KEY_VERIFY && !erase_refuse;

    // completion flag: any finishing event wins over the launch clear
    always_comb begin
        nxt_cmd_complete_flag = cmd_complete_flag_ff;
        if (launch_key || launch_ext) begin
            nxt_cmd_complete_flag = 1'b0;
        end
        if ((fif.done && (key_run_ff || !loaded_ff)) || (cmd_done_in && ext_run_ff)) begin
            nxt_cmd_complete_flag = 1'b1;
        end
    end

    always_comb begin
        nxt_complete_irq_enable = complete_irq_enable_ff;
        if (wr_take && avs_address_in == OFS_CONFIG && avs_byteenable_in[0]) begin
            nxt_complete_irq_enable = avs_writedata_in[CFG_COMPLETE_IRQ_ENABLE];
        end
    end

    // status flags, config, command and launch bookkeeping
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_complete_flag_ff      <= 1'b0;
            complete_irq_enable_ff      <= 1'b0;
            pviol_ff     <= 1'b0;
            keyrej_ff    <= 1'b0;
            key_run_ff   <= 1'b0;
            key_start_ff <= 1'b0;
            ext_run_ff   <= 1'b0;
            launch_ff    <= 1'b0;
            cmd_ff       <= 8'h00;
        end else if (ce_in) begin
            cmd_complete_flag_ff      <= nxt_cmd_complete_flag;
            complete_irq_enable_ff      <= nxt_complete_irq_enable;
            key_start_ff <= launch_key;
            launch_ff    <= launch_ext;
            // sticky errors: write one clears, a new refusal wins
            if (wr_take && avs_address_in == OFS_STATUS && avs_byteenable_in[0]) begin
                if (avs_writedata_in[ST_PVIOL]) begin
                    pviol_ff <= 1'b0;
                end
                if (avs_writedata_in[ST_KEYREJ]) begin
                    keyrej_ff <= 1'b0;
                end
            end
            if (launch_req && erase_refuse) begin
                pviol_ff <= 1'b1;
            end
            if (launch_req && key_refuse) begin
                keyrej_ff <= 1'b1;
            end
            if (launch_key) begin
                key_run_ff <= 1'b1;
            end else if (fif.done) begin
                key_run_ff <= 1'b0;
            end
            if (launch_ext) begin
                ext_run_ff <= 1'b1;
            end else if (cmd_done_in) begin
                ext_run_ff <= 1'b0;
            end
            // command code is locked while a command runs
            if (wr_take && avs_address_in == OFS_CMD && avs_byteenable_in[0] && cmd_complete_flag_ff) begin
                cmd_ff <= avs_writedata_in[7:0];
            end
        end
    end

    // presented keys, one per word, locked while a command runs
    generate
        for (genvar g = 0; g < NUM_KEYS; g++) begin : g_key
            always_ff @(posedge clk_in or posedge reset_in) begin
                if (reset_in) begin
                    key_ff[g] <= 16'h0000;
                end else if (ce_in && wr_take && cmd_complete_flag_ff &&
                             avs_address_in == OFS_KEY0 + 6'(g) * OFS_KEY_STEP) begin
                    if (avs_byteenable_in[0]) begin
                        key_ff[g][7:0] <= avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        key_ff[g][15:8] <= avs_writedata_in[15:8];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // protection transitions; size may only change from the open scenario
    assign wr_prot = avs_writedata_in[7:0] & PROT_MASK;

    always_comb begin
        case ({prot_ff[PROT_OPEN], prot_ff[PROT_HDIS]})
            2'b11:   prot_ok = 1'b1;
            2'b01:   prot_ok = wr_prot == prot_ff;
            2'b00:   prot_ok = !wr_prot[PROT_OPEN] &&
                               wr_prot[PROT_HS_LO +: 2] == prot_ff[PROT_HS_LO +: 2];
            2'b10:   prot_ok = (wr_prot[PROT_OPEN] ^ wr_prot[PROT_HDIS]) &&
                               wr_prot[PROT_HS_LO +: 2] == prot_ff[PROT_HS_LO +: 2];
            default: prot_ok = 1'b0;
        endcase
    end

    // protection register: flash load after reset, then guarded writes
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            prot_ff <= PROT_RST;
        end else if (ce_in) begin
            if (fif.done && !loaded_ff) begin
                prot_ff <= fif.prot_byte & PROT_MASK;
            end else if (wr_take && avs_address_in == OFS_PROT && avs_byteenable_in[0]
                         && prot_ok) begin
                prot_ff <= wr_prot;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // security state and key lockout
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sec_ff     <= SEC_RST;
            lock_ff    <= 1'b0;
            // reset state field decides the secured output
            secured_ff <= SEC_RST[SEC_STATE_LO +: 2] != SEC_UNSECURED;
        end else if (ce_in) begin
            if (fif.done && !loaded_ff) begin
                sec_ff     <= fif.sec_byte & SEC_MASK;
                secured_ff <= fif.sec_byte[SEC_STATE_LO +: 2] != SEC_UNSECURED;
            end else if (fif.done && key_run_ff) begin
                if (fif.match) begin
                    sec_ff[SEC_STATE_LO +: 2] <= SEC_UNSECURED;
                    secured_ff                <= 1'b0;
                end else begin
                    lock_ff <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration fetch after reset release
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            load_req_ff <= 1'b1;
            loaded_ff   <= 1'b0;
        end else if (ce_in) begin
            load_req_ff <= 1'b0;
            if (fif.done) begin
                loaded_ff <= 1'b1;
            end
        end
    end

    assign fif.start_load  = load_req_ff;
    assign fif.start_key   = key_start_ff;
    assign fif.flash_rdata = flash_rdata_in;
    assign fif.key         = key_ff;

    flash_fetch_seq u_fetch (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .ce_in    (ce_in),
        .fif      (fif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs: interrupt and protection decode
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_ff  <= 1'b0;
            high_ff <= 1'b0;
            low_ff  <= 1'b0;
            base_ff <= FA_TOP;
        end else if (ce_in) begin
            irq_ff  <= nxt_cmd_complete_flag && nxt_complete_irq_enable;
            // high when open differs from disable, low when closed
            high_ff <= prot_ff[PROT_OPEN] ^ prot_ff[PROT_HDIS];
            low_ff  <= !prot_ff[PROT_OPEN];
            // top region grows down by size
            base_ff <= FA_TOP - ((HIGH_MIN_SZ << prot_ff[PROT_HS_LO +: 2]) - 16'h0001);
        end
    end

    assign avs_waitrequest_out  = wait_ff;
    assign avs_readdata_out     = rdata_ff;
    assign flash_addr_out       = fif.flash_addr;
    assign flash_rd_out         = fif.flash_rd;
    assign flash_read_block_out = key_run_ff;
    assign cmd_launch_out       = launch_ff;
    assign cmd_code_out         = cmd_ff;
    assign irq_out              = irq_ff;
    assign prot_high_out        = high_ff;
    assign prot_low_out         = low_ff;
    assign high_base_out        = base_ff;
    assign secured_out          = secured_ff;
endmodule : flash_protect_security_ctrl

/* File: sim/flash_protect_security_ctrl_monitor.sv */
/* port checker for the flash protection controller.
   assumes a bind into the controller, with ce_in held high. */
module flash_protect_security_ctrl_monitor (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic flash_rd_out,
    input wire logic flash_read_block_out,
    input wire logic cmd_launch_out,
    input wire logic irq_out,
    input wire logic prot_high_out,
    input wire logic secured_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("bus not answered");
    wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    launch_pulse_a: assert property (cmd_launch_out |=> !cmd_launch_out)
        else $error("launch not a pulse");
    rd_pulse_a: assert property (flash_rd_out |=> !flash_rd_out)
        else $error("flash strobe not a pulse");
    high_sticky_a: assert property (prot_high_out |=> prot_high_out)
        else $error("high protection removed");
    unsecure_hold_a: assert property (!secured_out |=> !secured_out)
        else $error("security returned without reset");
    irq_quiet_a: assert property (flash_read_block_out && $past(flash_read_block_out)
        |-> !irq_out) else $error("irq during key verify");
    block_bound_a: assert property ($rose(flash_read_block_out)
        |-> ##[1:60] !flash_read_block_out) else $error("read block stuck");
    cover property ($rose(irq_out));
    cover property ($fell(secured_out));
    cover property ($rose(flash_read_block_out));
endmodule : flash_protect_security_ctrl_monitor
bind flash_protect_security_ctrl flash_protect_security_ctrl_monitor
    flash_protect_security_ctrl_monitor_i (.clk_in(clk_in), .reset_in(reset_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .flash_rd_out(flash_rd_out),
    .flash_read_block_out(flash_read_block_out), .cmd_launch_out(cmd_launch_out),
    .irq_out(irq_out), .prot_high_out(prot_high_out), .secured_out(secured_out));

/* File: sim/flash_protect_security_ctrl_tb_top.sv */
/* bench for the flash protection controller: protection table, irq, key verify.
   assumes a flash image answering one cycle after its read strobe. */
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module flash_protect_security_ctrl_tb_top import flash_prot_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in = 0, reset_in = 1, avs_read_in = 0, avs_write_in = 0, cmd_done_in = 0;
    logic [5:0]  avs_address_in = '0;
    logic [31:0] avs_writedata_in = '0, rdata, q;
    logic [7:0]  flash_rdata_in = '0, prot_b, sec_b, e, code;
    logic [15:0] flash_addr_out, high_base_out;
    logic [15:0] key [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
    logic        wreq, frd, blk, launch, irq, ph, pl, sec;
    int          fail_count = 0, tests_run = 0, cyc = 0, nblk = 0, nl = 0;
    logic [23:0] rows [8] = '{24'h002020, 24'h008000, 24'h200020, 24'h802020,
                              24'h80a080, 24'ha09898, 24'hb80000, 24'ha8b0b0};
    flash_protect_security_ctrl flash_protect_security_ctrl_i (.clk_in, .reset_in,
        .ce_in(1'b1), .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .flash_addr_out, .flash_rd_out(frd), .flash_rdata_in, .flash_read_block_out(blk),
        .cmd_launch_out(launch), .cmd_code_out(code), .cmd_done_in, .irq_out(irq),
        .prot_high_out(ph), .prot_low_out(pl), .high_base_out, .secured_out(sec));
    initial forever #12.5 clk_in = ~clk_in;
    function automatic logic [7:0] img(input logic [15:0] a);
        img = (a == FA_PROT) ? prot_b : (a == FA_SEC) ? sec_b : (a[15:3] == FA_KEY[15:3]) ?
            (a[0] ? key[a[2:1]][7:0] : key[a[2:1]][15:8]) : 8'hff;
    endfunction : img
    // flash registers data at the edge that sees its strobe, engine answers, watchdog
    always @(posedge clk_in) begin
        if (frd) flash_rdata_in <= img(flash_addr_out);
        cmd_done_in <= launch;
        nl <= nl + int'(launch);
        nblk <= nblk + int'(blk);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        // hold the request until waitrequest is sampled low at a rising edge
        do @(posedge clk_in); while (wreq !== 1'b0);
        q = rdata;
        avs_write_in <= 0;
        avs_read_in <= 0;
    endtask : bus
    task automatic wait_cc;
        do bus(0, OFS_STATUS, 0); while (q[ST_CMD_COMPLETE_FLAG] !== 1'b1);
    endtask : wait_cc
    task automatic boot(input logic [7:0] p, input logic [7:0] s);
        prot_b = p;
        sec_b = s;
        @(posedge clk_in);
        reset_in <= 1;
        repeat (8) @(posedge clk_in);
        `CHK({wreq, irq, sec, blk}, 4'b1010)
        reset_in <= 0;
        wait_cc();
    endtask : boot
    task automatic kv(input logic [15:0] k0);
        for (int i = 0; i < 4; i++)
            bus(1, 6'(OFS_KEY0 + OFS_KEY_STEP * i), 32'(i == 0 ? k0 : key[i]));
        bus(1, OFS_CMD, {24'h0, CMD_KEY_VERIFY});
        bus(1, OFS_STATUS, 32'h80);
        wait_cc();
    endtask : kv
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        for (int r = 0; r < 8; r++) begin
            boot(rows[r][23:16], 8'h00);
            bus(0, OFS_PROT, 0);
            `CHK(q, {24'h0, rows[r][23:16]})
            bus(1, OFS_PROT, {24'h0, rows[r][15:8]});
            bus(0, OFS_PROT, 0);
            e = rows[r][7:0];
            `CHK(q[7:0], e)
            `CHK({ph, pl}, {e[7] ^ e[5], !e[7]})
            if (ph === 1'b1) `CHK(high_base_out, 16'h0 - (HIGH_MIN_SZ << e[4:3]))
            $display("test protection row %0d done", r);
        end
        boot(8'h00, 8'h00);
        bus(1, OFS_CONFIG, 32'h80);
        @(negedge clk_in) `CHK(irq, 1'b1)
        bus(1, OFS_CMD, 32'h01);
        bus(1, OFS_STATUS, 32'h80);
        `CHK(code, 8'h01)
        wait_cc();
        `CHK({nl, irq}, {32'd1, 1'b1})
        bus(1, OFS_CMD, {24'h0, CMD_ERASE_ALL});
        bus(1, OFS_STATUS, 32'h80);
        bus(0, OFS_STATUS, 0);
        `CHK({q[ST_PVIOL], nl}, {1'b1, 32'd1})
        bus(1, OFS_CONFIG, 0);
        @(negedge clk_in) `CHK(irq, 1'b0)
        $display("test irq and launch done");
        boot(8'hb8, 8'h80);
        kv(16'h1111);
        `CHK({nblk != 0, sec}, 2'b11)
        kv(key[0]);
        `CHK({q[ST_KEYREJ], sec}, 2'b11)
        boot(8'hb8, 8'h80);
        kv(key[0]);
        `CHK(sec, 1'b0)
        bus(0, OFS_SEC, 0);
        `CHK(q[7:0], 8'h82)
        bus(0, OFS_PROT, 0);
        `CHK(q[7:0], 8'hb8)
        boot(8'hb8, 8'h40);
        kv(key[0]);
        `CHK({q[ST_KEYREJ], sec}, 2'b11)
        $display("test key verify done");
        print_verdict();
    end
endmodule : flash_protect_security_ctrl_tb_top
